/* rtl/ols_core.sv */
// open-loop step control: internal, step/direction and analog modes
//
// Behaviour
// - 2048 generic microsteps make one wfm-step
// - speed command sets rate, resolution auto
// - from 60 up no finest fine-waveform resolution
// - external inputs XORed, bypass internal generator
// - direction inverted after last forward run
// - each external pulse is one microstep
// - wfm-step rate is pulse rate over resolution
// - power on loads waveform and resolution
// - save command writes waveform, resolution and park
// - saved parked state stays parked
// - parked motor ignores step/direction input
// - analog mode while run input low
// - run input high stops analog motion
// - low direction input reverses analog motion
// - limit switches ignored in analog mode
// - mode 01 uses fine 2048 linear
// - modes 10,00 auto resolution, non-linear speed
// - mode 11 keeps last settings, linear
// - analog motion kept between position limits
// - leaving analog mode holds present position
// - equal limits disable hold and range
`timescale 1ns/1ns
`include "ols_defs.svh"

module ols_core (
	input  wire logic             mclk_i,     // system clock
	input  wire logic             rst_b_i,    // synchronous reset
	input  wire ols_pkg::ols_bus_t bus_i,     // register bus request
	output logic [31:0]           rdata_o,    // read data, cycle after read
	input  wire logic             step_i,     // external step pin
	input  wire logic             dir_i,      // external direction pin
	input  wire logic             run_b_i,    // analog run pin, low active
	input  wire logic             mode6_i,    // analog mode select pin 6
	input  wire logic             mode7_i,    // analog mode select pin 7
	input  wire logic [9:0]       level_i,    // sampled analog level
	input  wire logic [31:0]      pos_i,      // quadrature position, signed
	input  wire ols_pkg::ols_nv_t nv_i,       // stored settings image
	output logic                  ustep_o,    // one microstep pulse
	output logic                  udir_o,     // microstep direction, 1 fwd
	output logic [3:0]            res_o,      // log2 microsteps per wfm-step
	output logic                  hold_o,     // closed-loop hold request
	output logic                  nv_save_o,  // store pulse
	output ols_pkg::ols_nv_t      nv_o        // settings to store
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// automatic resolution from rate and waveform
	// slow band is strictly below the threshold rate: at the threshold
	// itself the finest setting is already dropped
	// faster rates take coarser settings so the microstep rate stays bounded
	function automatic logic [3:0] auto_res(input logic [15:0] rate, input ols_pkg::ols_wave_t wave);
		if (rate < `OLS_SLOW_MAX) begin
			auto_res = (wave == ols_pkg::OLS_WAVE_FINE) ? `OLS_RES_FINEST : `OLS_RES_FINE;
		end else if (rate <= `OLS_MID_MAX) begin
			auto_res = `OLS_RES_MID;
		end else begin
			auto_res = `OLS_RES_COARSE;
		end
	endfunction

	// microsteps per second for a rate and resolution
	// a 16-bit rate shifted by at most fifteen fits the word
	function automatic logic [31:0] ustep_rate(input logic [15:0] rate, input logic [3:0] res);
		ustep_rate = {16'h0000, rate} << res;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// all state lives in one packed struct, registered in one place
	ols_pkg::ols_state_t s_r;    // registered state
	ols_pkg::ols_state_t s_nxt;  // next state

	// decode helpers, driven only by the next-state process
	logic        in_analog;      // analog run held low
	logic [10:0] diff;           // level minus stop level, signed
	logic [9:0]  mag;            // magnitude of difference
	logic        a_pos;          // level above stop
	logic        in_band;        // inside stop band
	logic [15:0] a_rate;         // analog rate
	logic [3:0]  res_sel;        // resolution in use
	logic [31:0] add;            // accumulator step
	logic        gen_tick;       // generator wants a microstep
	logic        want_fwd;       // direction of the next microstep
	logic        lim_on;         // position limits active
	logic        lim_block;      // motion blocked by limit
	logic [31:0] lo;             // lower limit
	logic [31:0] hi;             // upper limit
	logic [31:0] cost;           // generic units per microstep

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	// one process computes the whole next state from the registered copy
	// pulse fields and read data default to zero every cycle
	always_comb begin
		s_nxt = s_r;
		s_nxt.ustep = 1'b0;
		s_nxt.nv_save = 1'b0;
		s_nxt.rdata = 32'h00000000;
		gen_tick = 1'b0;
		want_fwd = s_r.fwd;
		lim_block = 1'b0;

		// pin synchronisers, second stage only read below
		s_nxt.step_s = {s_r.step_s[0], step_i};
		s_nxt.dir_s = {s_r.dir_s[0], dir_i};
		s_nxt.run_s = {s_r.run_s[0], run_b_i};
		s_nxt.m6_s = {s_r.m6_s[0], mode6_i};
		s_nxt.m7_s = {s_r.m7_s[0], mode7_i};
		// the level word is held steady by the converter between samples
		s_nxt.lvl_s = {s_r.lvl_s[9:0], level_i};
		s_nxt.step_prev = s_r.step_s[1];

		// power-on load of stored settings, one cycle after release
		// register writes later in this process win over the load
		if (!s_r.init_done) begin
			s_nxt.init_done = 1'b1;
			s_nxt.cfg = nv_i;
		end

		// analog level decode
		in_analog = !s_r.run_s[1];
		diff = {1'b0, s_r.lvl_s[19:10]} - {1'b0, s_r.stop_lvl};
		a_pos = !diff[10];
		mag = a_pos ? diff[9:0] : 10'((~diff) + 11'h001);
		in_band = (mag <= s_r.stop_bnd);
		if ({s_r.m6_s[1], s_r.m7_s[1]} == 2'b01 || {s_r.m6_s[1], s_r.m7_s[1]} == 2'b11) begin
			// linear law: one wfm-step per second per level count
			a_rate = {6'h00, mag};
		end else begin
			// square law over 16, product kept 32 bits wide so that
			// large offsets do not wrap before the shift
			a_rate = 16'(({22'h000000, mag} * {22'h000000, mag}) >> 4);
		end

		// resolution in use per mode
		case (s_r.mode)
			ols_pkg::OLS_RUN_INT: res_sel = auto_res(s_r.speed, s_r.cfg.wave);
			ols_pkg::OLS_ANALOG: begin
				case ({s_r.m6_s[1], s_r.m7_s[1]})
					2'b01:   res_sel = `OLS_RES_FINEST;
					2'b11:   res_sel = s_r.cfg.res;
					default: res_sel = auto_res(a_rate, s_r.cfg.wave);
				endcase
			end
			default: res_sel = s_r.cfg.res;
		endcase
		s_nxt.res_out = res_sel;

		// position limits
		// limits may be written in either order, sorted here
		lim_on = (s_r.lim_a != s_r.lim_b);
		lo = ($signed(s_r.lim_a) < $signed(s_r.lim_b)) ? s_r.lim_a : s_r.lim_b;
		hi = ($signed(s_r.lim_a) < $signed(s_r.lim_b)) ? s_r.lim_b : s_r.lim_a;

		// register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				`OLS_ADDR_CTRL: begin
					s_nxt.fwd = bus_i.wdata[`OLS_CTRL_FWD];
					s_nxt.cfg.park = bus_i.wdata[`OLS_CTRL_PARK];
					s_nxt.sdir_en = bus_i.wdata[`OLS_CTRL_SDIR];
					// a save stores the settings as they stood before this write
					if (bus_i.wdata[`OLS_CTRL_SAVE]) begin
						s_nxt.nv_save = 1'b1;
						s_nxt.nv_out = s_r.cfg;
					end
				end
				`OLS_ADDR_USTEP: begin
					// a start while busy or parked only reloads the count, unless an internal run ticks that cycle,
					// and clears the accumulator outside internal and analog runs
					s_nxt.rem = bus_i.wdata;
					s_nxt.acc = 32'h00000000;
					if (s_r.mode == ols_pkg::OLS_IDLE && !s_r.cfg.park && bus_i.wdata != 32'h00000000) begin
						s_nxt.mode = ols_pkg::OLS_RUN_INT;
						// direction of this run steers later step/direction sense
						s_nxt.last_fwd = s_r.fwd;
						s_nxt.hold = 1'b0;
					end
				end
				`OLS_ADDR_SPEED:   s_nxt.speed = bus_i.wdata[15:0];
				`OLS_ADDR_CFG: begin
					s_nxt.cfg.wave = ols_pkg::ols_wave_t'(bus_i.wdata[1:0]);
					s_nxt.cfg.res = bus_i.wdata[7:4];
				end
				`OLS_ADDR_LIM_A:   s_nxt.lim_a = bus_i.wdata;
				`OLS_ADDR_LIM_B:   s_nxt.lim_b = bus_i.wdata;
				`OLS_ADDR_STOPLVL: s_nxt.stop_lvl = bus_i.wdata[9:0];
				`OLS_ADDR_STOPBND: s_nxt.stop_bnd = bus_i.wdata[9:0];
				default: ;
			endcase
		end

		// register reads, unmapped reads zero
		// status packs busy, flags, mode and resolution for software
		if (bus_i.rd) begin
			case (bus_i.addr)
				`OLS_ADDR_CTRL:    s_nxt.rdata = {27'h0, 1'b0, s_r.sdir_en, s_r.cfg.park, s_r.fwd, 1'b0};
				`OLS_ADDR_USTEP:   s_nxt.rdata = s_r.rem;
				`OLS_ADDR_SPEED:   s_nxt.rdata = {16'h0000, s_r.speed};
				`OLS_ADDR_CFG:     s_nxt.rdata = {24'h000000, s_r.cfg.res, 2'b00, s_r.cfg.wave};
				`OLS_ADDR_LIM_A:   s_nxt.rdata = s_r.lim_a;
				`OLS_ADDR_LIM_B:   s_nxt.rdata = s_r.lim_b;
				`OLS_ADDR_STOPLVL: s_nxt.rdata = {22'h000000, s_r.stop_lvl};
				`OLS_ADDR_STOPBND: s_nxt.rdata = {22'h000000, s_r.stop_bnd};
				`OLS_ADDR_STATUS:  s_nxt.rdata = {20'h00000, s_r.res_out, 2'b00, s_r.mode, s_r.hold,
				                                  s_r.last_fwd, s_r.cfg.park, s_r.mode != ols_pkg::OLS_IDLE};
				default:           s_nxt.rdata = 32'h00000000;
			endcase
		end

		// rate generator: the accumulator adds microsteps per second
		// each clock and emits a microstep each time it passes the clock rate
		// cost is the generic count that one microstep uses up
		cost = 32'h00000001 << (`OLS_GEN_PER_WFM - res_sel);
		case (s_r.mode)
			ols_pkg::OLS_RUN_INT: add = ustep_rate(s_r.speed, res_sel);
			ols_pkg::OLS_ANALOG:  add = ustep_rate(a_rate, res_sel);
			default:              add = 32'h00000000;
		endcase
		if (s_r.mode == ols_pkg::OLS_RUN_INT || s_r.mode == ols_pkg::OLS_ANALOG) begin
			if (s_r.acc + add >= `OLS_CLK_HZ) begin
				s_nxt.acc = s_r.acc + add - `OLS_CLK_HZ;
				gen_tick = 1'b1;
			end else begin
				s_nxt.acc = s_r.acc + add;
			end
		end

		// mode sequencing
		case (s_r.mode)
			ols_pkg::OLS_IDLE: begin
				// analog run takes priority over step/direction enable
				if (in_analog) begin
					s_nxt.mode = ols_pkg::OLS_ANALOG;
					s_nxt.hold = 1'b0;
					s_nxt.acc = 32'h00000000;
				end else if (s_r.sdir_en && !s_r.cfg.park) begin
					s_nxt.mode = ols_pkg::OLS_STEPDIR;
				end
			end
			ols_pkg::OLS_RUN_INT: begin
				if (gen_tick && !s_r.cfg.park) begin
					s_nxt.ustep = 1'b1;
					want_fwd = s_r.fwd;
					s_nxt.rem = s_r.rem - cost;
				end
				// a remainder below one microstep is dropped, not stepped
				if (s_r.rem < cost || s_r.cfg.park || in_analog) begin
					s_nxt.mode = ols_pkg::OLS_IDLE;
					s_nxt.ustep = 1'b0;
				end
			end
			ols_pkg::OLS_STEPDIR: begin
				// external pins drive the motor directly
				// an edge is a high second stage over a low previous sample
				want_fwd = s_r.dir_s[1] ^ s_r.last_fwd;
				if (s_r.step_s[1] && !s_r.step_prev) begin
					s_nxt.ustep = 1'b1;
				end
				// park, disable or analog entry drop back to idle at once
				if (!s_r.sdir_en || s_r.cfg.park || in_analog) begin
					s_nxt.mode = ols_pkg::OLS_IDLE;
					s_nxt.ustep = 1'b0;
				end
			end
			ols_pkg::OLS_ANALOG: begin
				// sign of the offset sets direction, a low dir pin flips it
				want_fwd = a_pos ^ !s_r.dir_s[1];
				if (lim_on) begin
					lim_block = want_fwd ? ($signed(pos_i) >= $signed(hi)) : ($signed(pos_i) <= $signed(lo));
				end
				// limit switch pins are not consulted here
				if (gen_tick && !in_band && !lim_block && !s_r.cfg.park) begin
					s_nxt.ustep = 1'b1;
				end
				if (!in_analog) begin
					s_nxt.mode = ols_pkg::OLS_IDLE;
					s_nxt.ustep = 1'b0;
					// hand over to the position hold only if limits differ
					s_nxt.hold = lim_on;
				end
			end
			default: s_nxt.mode = ols_pkg::OLS_IDLE;
		endcase
		if (s_nxt.ustep) begin
			s_nxt.udir = want_fwd;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// synchronous reset; park held until the stored image is loaded
	// run synchroniser resets high so no false analog entry follows
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.speed <= `OLS_SPEED_RST;
			s_r.stop_lvl <= `OLS_STOPLVL_RST;
			s_r.stop_bnd <= `OLS_STOPBND_RST;
			s_r.run_s <= 2'b11;
			s_r.cfg.park <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	// no logic after the flops, so outputs cannot glitch
	assign rdata_o = s_r.rdata;
	assign ustep_o = s_r.ustep;
	assign udir_o = s_r.udir;
	assign res_o = s_r.res_out;
	assign hold_o = s_r.hold;
	assign nv_save_o = s_r.nv_save;
	assign nv_o = s_r.nv_out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// properties look one cycle on at the registered outputs (a_sdir_edge and a_save_image also two), a_park_no_step one cycle back
	a_park_no_step: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ustep_o |-> !$past(s_r.cfg.park)) else $error("microstep while parked");

	a_fast_not_finest: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_RUN_INT && s_r.speed >= `OLS_SLOW_MAX) |=> res_o != `OLS_RES_FINEST)
		else $error("finest resolution above slow rate");

	a_sdir_dir: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_STEPDIR && s_nxt.mode == ols_pkg::OLS_STEPDIR && s_nxt.ustep)
		|=> udir_o == ($past(s_r.dir_s[1]) ^ $past(s_r.last_fwd))) else $error("step direction sense wrong");

	a_sdir_edge: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_STEPDIR && !s_r.step_prev && s_r.step_s[1] && s_r.sdir_en
		&& !s_r.cfg.park && s_r.run_s[1]) |=> ustep_o ##1 !ustep_o) else $error("external pulse lost");

	a_mode01_fine: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_ANALOG && s_r.m6_s[1] == 1'b0 && s_r.m7_s[1] == 1'b1)
		|=> res_o == `OLS_RES_FINEST) else $error("mode 01 not finest");

	a_band_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_ANALOG && in_band) |=> !ustep_o) else $error("step inside stop band");

	a_exit_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_ANALOG && s_r.run_s[1] && s_r.lim_a != s_r.lim_b)
		|=> hold_o && s_r.mode == ols_pkg::OLS_IDLE) else $error("no hold after analog exit");

	a_save_image: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(bus_i.wr && bus_i.addr == `OLS_ADDR_CTRL && bus_i.wdata[`OLS_CTRL_SAVE])
		|=> nv_save_o && nv_o == $past(s_r.cfg) ##1 !nv_save_o) else $error("save image wrong");

	a_limit_stop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_ANALOG && lim_block) |=> !ustep_o) else $error("step past limit");

	a_exit_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_ANALOG && s_r.run_s[1]) |=> !ustep_o) else $error("step after analog exit");

	a_equal_no_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(s_r.mode == ols_pkg::OLS_ANALOG && s_r.run_s[1] && s_r.lim_a == s_r.lim_b)
		|=> !hold_o) else $error("hold with equal limits");

endmodule // ols_core

/* rtl/ols_defs.svh */
// constants of the open-loop step control block
`ifndef OLS_DEFS_SVH
`define OLS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OLS_ADDR_CTRL    8'h00
`define OLS_ADDR_USTEP   8'h04
`define OLS_ADDR_SPEED   8'h08
`define OLS_ADDR_CFG     8'h0C
`define OLS_ADDR_LIM_A   8'h10
`define OLS_ADDR_LIM_B   8'h14
`define OLS_ADDR_STOPLVL 8'h18
`define OLS_ADDR_STOPBND 8'h1C
`define OLS_ADDR_STATUS  8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OLS_CTRL_FWD     1
`define OLS_CTRL_PARK    2
`define OLS_CTRL_SDIR    3
`define OLS_CTRL_SAVE    4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define OLS_SPEED_RST    16'h0064
`define OLS_STOPLVL_RST  10'h1FF
`define OLS_STOPBND_RST  10'h002
`define OLS_CLK_HZ       32'h05F5E100
`define OLS_SLOW_MAX     16'h003C
`define OLS_MID_MAX      16'h0258
`define OLS_RES_FINEST   4'hB
`define OLS_RES_FINE     4'hA
`define OLS_RES_MID      4'h8
`define OLS_RES_COARSE   4'h6
`define OLS_GEN_PER_WFM  4'hB

`endif

/* rtl/ols_pkg.sv */
// types of the open-loop step control block
package ols_pkg;

	// operating mode
	typedef enum logic [1:0] {OLS_IDLE, OLS_RUN_INT, OLS_STEPDIR, OLS_ANALOG} ols_mode_t;

	// waveform selector
	typedef enum logic [1:0] {OLS_WAVE_COARSE, OLS_WAVE_MID, OLS_WAVE_FINE, OLS_WAVE_SPARE} ols_wave_t;

	// register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ols_bus_t;

	// nonvolatile settings image
	typedef struct packed {
		ols_wave_t  wave;
		logic [3:0] res;
		logic       park;
	} ols_nv_t;

	// whole block state
	typedef struct packed {
		ols_mode_t    mode;
		ols_nv_t      cfg;
		logic [15:0]  speed;
		logic         fwd;
		logic         sdir_en;
		logic [31:0]  rem;
		logic [31:0]  acc;
		logic [31:0]  lim_a;
		logic [31:0]  lim_b;
		logic [9:0]   stop_lvl;
		logic [9:0]   stop_bnd;
		logic [1:0]   step_s;
		logic [1:0]   dir_s;
		logic [1:0]   run_s;
		logic [1:0]   m6_s;
		logic [1:0]   m7_s;
		logic [19:0]  lvl_s;
		logic         step_prev;
		logic         last_fwd;
		logic         hold;
		logic         init_done;
		logic         ustep;
		logic         udir;
		logic [3:0]   res_out;
		logic [31:0]  rdata;
		logic         nv_save;
		ols_nv_t      nv_out;
	} ols_state_t;

endpackage

/* test/ols_core_bench.sv */
// self-checking bench of the open-loop step control core
`timescale 1ns/1ns
`include "ols_defs.svh"

module ols_core_bench;
	// ------------------------------------------------
	// signals
	// ------------------------------------------------
	logic              mclk_i  = 1'b0;     // system clock
	logic              rst_b_i = 1'b0;     // reset, low active
	ols_pkg::ols_bus_t bus_i   = '0;       // register requests
	logic [31:0]       rdata_o;            // read data
	logic              step_w;             // step pin from the model
	logic              dir_i   = 1'b1;     // direction pin
	logic              run_b_i = 1'b1;     // analog run pin, idle high
	logic              mode6_i = 1'b0;     // analog mode pin 6
	logic              mode7_i = 1'b0;     // analog mode pin 7
	logic [9:0]        level_i = 10'h1FF;  // analog sample
	logic [31:0]       pos_i   = 32'h96;   // position feedback
	ols_pkg::ols_nv_t  nv_i    = '{ols_pkg::OLS_WAVE_FINE, 4'h9, 1'b0};  // stored image
	logic              ustep_o, udir_o, hold_o, nv_save_o;               // core pins
	logic [3:0]        res_o;              // resolution out
	ols_pkg::ols_nv_t  nv_o;               // image to store
	logic              sd_go   = 1'b0;     // model start
	logic [7:0]        sd_cnt  = 8'h00;    // model pulse count
	logic              sd_busy;            // model running
	int                failures = 0;       // mismatches
	int                tests_run = 0;      // comparisons
	int                nst = 0;            // microsteps seen
	logic              ud;                 // direction at last microstep
	logic [3:0]        ures;               // resolution at last microstep

	// internal run table row and analog table row
	typedef struct {logic [15:0] spd; logic [31:0] us; logic fwd; logic [3:0] res; logic [31:0] n;} ols_run_row_t;
	typedef struct {logic m6; logic m7; logic [9:0] lvl; logic dir; logic [31:0] pos;
		logic [3:0] res; logic mv; logic ud;} ols_an_row_t;
	ols_run_row_t runs [5] = '{
		'{16'h003B, 32'h1,   1'b1, 4'hB, 32'h1},   // 59: finest fine resolution
		'{16'h003C, 32'h8,   1'b1, 4'h8, 32'h1},   // 60: finest dropped
		'{16'h0258, 32'h8,   1'b1, 4'h8, 32'h1},   // 600: upper edge of mid band
		'{16'h0259, 32'h20,  1'b1, 4'h6, 32'h1},   // 601: coarse
		'{16'hC350, 32'h800, 1'b0, 4'h6, 32'h40}}; // one wfm-step, reverse last
	ols_an_row_t an [7] = '{
		'{1'b0, 1'b1, 10'h209, 1'b1, 32'h96, 4'hB, 1'b1, 1'b1},  // 01 forward
		'{1'b0, 1'b1, 10'h209, 1'b0, 32'h96, 4'hB, 1'b1, 1'b0},  // direction pin low reverses
		'{1'b1, 1'b0, 10'h227, 1'b1, 32'h96, 4'h8, 1'b1, 1'b1},  // 10 non-linear
		'{1'b0, 1'b0, 10'h1D7, 1'b1, 32'h96, 4'h8, 1'b1, 1'b0},  // 00 below stop level
		'{1'b1, 1'b1, 10'h38F, 1'b1, 32'h96, 4'h5, 1'b1, 1'b1},  // 11 last settings
		'{1'b0, 1'b1, 10'h201, 1'b1, 32'h96, 4'hF, 1'b0, 1'b1},  // inside stop band
		'{1'b0, 1'b1, 10'h209, 1'b1, 32'hFA, 4'hF, 1'b0, 1'b1}}; // beyond upper limit

	// ------------------------------------------------
	// clock, instances, step monitor
	// ------------------------------------------------
	always #5 mclk_i = ~mclk_i;

	ols_core ols_core_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.step_i(step_w), .dir_i(dir_i), .run_b_i(run_b_i), .mode6_i(mode6_i), .mode7_i(mode7_i),
		.level_i(level_i), .pos_i(pos_i), .nv_i(nv_i), .ustep_o(ustep_o), .udir_o(udir_o),
		.res_o(res_o), .hold_o(hold_o), .nv_save_o(nv_save_o), .nv_o(nv_o));
	ols_sd_src ols_sd_src_inst (.mclk_i(mclk_i), .go_i(sd_go), .cnt_i(sd_cnt), .step_o(step_w), .busy_o(sd_busy));

	// count microsteps and note what came with the last one
	always @(posedge mclk_i) begin
		if (ustep_o === 1'b1) begin
			nst <= nst + 1;
			ud <= udir_o;
			ures <= res_o;
		end
	end

	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic report_and_stop;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic tmo;
		failures++;
		$display("MISMATCH t=%0t wait ran out", $time);
		report_and_stop();
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk_i);
		bus_i.wr <= 1'b0;
	endtask

	task automatic br(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		bus_i <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk_i);
		bus_i.rd <= 1'b0;
		#1 d = rdata_o;
	endtask

	// read a register and compare the masked bits
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		logic [31:0] d;
		br(a, d);
		chk_val(d & msk, exp, "register read");
	endtask

	task automatic wait_idle;
		logic [31:0] d;
		int i;
		for (i = 0; i < 5000; i++) begin
			br(`OLS_ADDR_STATUS, d);
			if (d[0] === 1'b0) break;
		end
		if (i == 5000) tmo();
	endtask

	task automatic do_run(input ols_run_row_t r);
		int n0;
		bw(`OLS_ADDR_CTRL, {30'h0, r.fwd, 1'b0});
		bw(`OLS_ADDR_SPEED, {16'h0, r.spd});
		n0 = nst;
		bw(`OLS_ADDR_USTEP, r.us);
		wait_idle();
		repeat (4) @(posedge mclk_i);
		chk_val(nst - n0, r.n, "run steps");
		chk_val(ures, r.res, "run resolution");
	endtask

	task automatic sd_burst(input logic [7:0] c, input logic d);
		int i;
		@(posedge mclk_i);
		sd_go <= 1'b1;
		sd_cnt <= c;
		dir_i <= d;
		@(posedge mclk_i);
		sd_go <= 1'b0;
		@(posedge mclk_i);
		for (i = 0; i < 20000 && sd_busy === 1'b1; i++) @(posedge mclk_i);
		if (i == 20000) tmo();
		repeat (6) @(posedge mclk_i);
	endtask

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		int n0;
		repeat (9) @(posedge mclk_i);
		chk_val({ustep_o, hold_o, nv_save_o, res_o}, 32'h0, "outputs in reset");
		@(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk_reg(`OLS_ADDR_STATUS, 32'h0000_0900, 32'h0000_0F02);
		chk_reg(8'h24, 32'h0, 32'hFFFF_FFFF);
		// save while parked: the stored image keeps the park
		bw(`OLS_ADDR_CTRL, 32'h0000_0004);
		bw(`OLS_ADDR_CTRL, 32'h0000_0014);
		#1;
		chk_val(nv_save_o, 1'b1, "save pulse");
		chk_val(nv_o, {ols_pkg::OLS_WAVE_FINE, 4'h9, 1'b1}, "saved image");
		@(posedge mclk_i);
		#1;
		chk_val(nv_save_o, 1'b0, "save pulse ends");
		chk_reg(`OLS_ADDR_CTRL, 32'h0000_0004, 32'h0000_0014);
		// parked motor ignores step pulses
		bw(`OLS_ADDR_CTRL, 32'h0000_000C);
		n0 = nst;
		sd_burst(8'h02, 1'b1);
		chk_val(nst - n0, 32'h0, "parked steps");
		foreach (runs[k]) do_run(runs[k]);
		// step/direction after a reverse run, then after a forward run
		for (int f = 0; f < 2; f++) begin
			if (f == 1) do_run(runs[0]);
			bw(`OLS_ADDR_CFG, 32'h0000_0052);
			bw(`OLS_ADDR_CTRL, 32'h0000_0008);
			n0 = nst;
			sd_burst(8'h03, 1'b1);
			chk_val(nst - n0, 32'h3, "pulse steps");
			chk_val(ud, f == 0, "pulse direction");
			chk_val(ures, 4'h5, "pulse resolution");
		end
		// analog modes with limits 100 and 200
		bw(`OLS_ADDR_CTRL, 32'h0);
		bw(`OLS_ADDR_LIM_A, 32'h64);
		bw(`OLS_ADDR_LIM_B, 32'hC8);
		foreach (an[k]) begin
			@(posedge mclk_i);
			mode6_i <= an[k].m6;
			mode7_i <= an[k].m7;
			level_i <= an[k].lvl;
			dir_i <= an[k].dir;
			pos_i <= an[k].pos;
			run_b_i <= 1'b0;
			repeat (10) @(posedge mclk_i);
			n0 = nst;
			repeat (9000) @(posedge mclk_i);
			chk_val(nst != n0, an[k].mv, "analog motion");
			if (an[k].mv) chk_val(ud, an[k].ud, "analog direction");
			if (an[k].res != 4'hF) chk_val(ures, an[k].res, "analog resolution");
		end
		// leaving analog mode: motion stops, hold requested
		run_b_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		chk_val(hold_o, 1'b1, "hold after exit");
		n0 = nst;
		repeat (20) @(posedge mclk_i);
		chk_val(nst - n0, 32'h0, "steps after exit");
		// equal limits: no hold on exit
		bw(`OLS_ADDR_LIM_B, 32'h64);
		run_b_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		run_b_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		chk_val(hold_o, 1'b0, "hold with equal limits");
		report_and_stop();
	end
endmodule // ols_core_bench

/* test/ols_sd_src.sv */
// external step/direction controller model: bursts of step pulses
`timescale 1ns/1ns

module ols_sd_src #(
	parameter int HALF = 420               // clocks per half period of the step pin
) (
	input  wire logic       mclk_i,        // system clock
	input  wire logic       go_i,          // start a burst
	input  wire logic [7:0] cnt_i,         // pulses in the burst
	output logic            step_o,        // step pin, idles low
	output logic            busy_o         // burst in progress
);
	// ------------------------------------------------
	// pulse generator
	// ------------------------------------------------
	int n;                                 // pulses taken at burst start

	initial begin
		step_o = 1'b0;
		busy_o = 1'b0;
	end

	// 420 clocks each half: about 119 kHz, kept under the pin rate limit
	always @(posedge mclk_i) begin
		if (go_i === 1'b1 && busy_o === 1'b0) begin
			busy_o <= 1'b1;
			n = cnt_i;
			repeat (HALF) @(posedge mclk_i);
			for (int k = 0; k < n; k++) begin
				step_o <= 1'b1;
				repeat (HALF) @(posedge mclk_i);
				step_o <= 1'b0;
				repeat (HALF) @(posedge mclk_i);
			end
			busy_o <= 1'b0;
		end
	end
endmodule // ols_sd_src
